// >>> shared/reset_seq_pkg.sv
// constants and types shared by the cold/warm reset sequencer
// Operation
// - While reset input is low, straps are sampled every cycle into the configuration.
// - Bus activity begins a few cycles after reset output release, never before.
// - In ISA mode, PCI cycles appear before any ISA cycles.
// - In local bus mode, no PCI access; flash chip select shows boot activity.
// - Warm reset behaves exactly like cold reset for straps and bus order.
// - While reset input is low, the PCI clock PLL runs open loop, hundreds of kHz.
package reset_seq_pkg;
	localparam int CLK_KHZ = 25000;
	localparam int STRAP_W = 8;
	// strap bit that selects ISA mode (1) or local bus mode (0)
	localparam int STRAP_ISA_BIT = 0;
	localparam int CNT_W = 8;
	localparam int RELEASE_HOLD_NS = 1000;
	localparam int RELEASE_HOLD_CYC = (RELEASE_HOLD_NS * CLK_KHZ + 999999) / 1000000;
	localparam int BUS_START_CYC = 4;
	localparam int PCI_LEAD_CYC = 8;
	localparam int OPEN_LOOP_KHZ = 300;
	localparam int OPEN_HALF_CYC = CLK_KHZ / (2 * OPEN_LOOP_KHZ);
	localparam int LOCK_NS = 2000;
	localparam int LOCK_CYC = (LOCK_NS * CLK_KHZ + 999999) / 1000000;
	localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_SETTLE,
		ST_RELEASE,
		ST_PCI,
		ST_RUN
	} seq_state_type;
endpackage

// >>> shared/pll_link_if.sv
// control and status between the sequencer and the PCI clock PLL
`timescale 1ns/1ps
interface pll_link_if;
	logic open_loop;
	logic clk_out;
	logic settled;
	modport ctrl (output open_loop, input clk_out, input settled);
	modport pll (input open_loop, output clk_out, output settled);
endinterface

// >>> hdl/pci_clock_pll.sv
// behavioural stand-in for the PCI clock PLL: open-loop slow clock or locked clock
`timescale 1ns/1ps
module pci_clock_pll (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// sequencer side
	pll_link_if.pll link
);
	localparam int CW = reset_seq_pkg::CNT_W;

	typedef struct packed {
		logic [CW-1:0] div;
		logic [CW-1:0] lock;
		logic clk;
		logic settled;
	} pll_state_type;

	pll_state_type s;
	pll_state_type next_s;

	always_comb begin
		next_s = s;
		if (link.open_loop) begin
			// open loop: slow free-running clock, never reported as settled
			next_s.settled = 1'b0;
			next_s.lock = '0;
			if (s.div == CW'(reset_seq_pkg::OPEN_HALF_CYC - 1)) begin
				next_s.div = '0;
				next_s.clk = ~s.clk;
			end else begin
				next_s.div = s.div + 1'b1;
			end
		end else begin
			next_s.div = '0;
			next_s.clk = ~s.clk;
			if (s.lock == CW'(reset_seq_pkg::LOCK_CYC - 1)) begin
				next_s.settled = 1'b1;
			end else begin
				next_s.lock = s.lock + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.clk_out = s.clk;
	assign link.settled = s.settled;

	open_unsettled_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		link.open_loop |=> !link.settled)
		else $error("pll reported settled while open loop");
endmodule

// >>> hdl/cold_warm_reset_sequencer.sv
// cold/warm reset sequencer: strap capture, reset output release, boot bus order
`timescale 1ns/1ps
module cold_warm_reset_sequencer #(
	parameter int STRAP_W = reset_seq_pkg::STRAP_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// system reset and straps
	input wire logic sys_reset_in_n,
	input wire logic [STRAP_W-1:0] strap_in,
	// reset output and configuration
	output logic sys_reset_out_n,
	output logic [STRAP_W-1:0] strap_cfg,
	// bus activity enables
	output logic pci_active,
	output logic isa_active,
	output logic flash_cs_n,
	// PCI clock PLL observation
	output logic pll_open_loop,
	output logic pci_clk
);
	localparam int CW = reset_seq_pkg::CNT_W;
	localparam int ISA = reset_seq_pkg::STRAP_ISA_BIT;

	typedef struct packed {
		reset_seq_pkg::seq_state_type state;
		logic [CW-1:0] cnt;
		logic [STRAP_W-1:0] cfg;
		logic out_n;
		logic pci;
		logic isa;
		logic flash_n;
		logic open_loop;
		logic pclk;
	} seq_type;

	logic [1:0] rst_sync;
	logic rst_n;
	seq_type s;
	seq_type next_s;
	pll_link_if link ();

	// release of the local reset is synchronised; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	pci_clock_pll u_pll (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.link(link)
	);
	assign link.open_loop = s.open_loop;

	always_comb begin
		next_s = s;
		next_s.pclk = link.clk_out;
		if (!sys_reset_in_n) begin
			// same path for power-on and warm reset: nothing depends on history
			next_s.state = reset_seq_pkg::ST_HOLD;
			next_s.cnt = '0;
			next_s.cfg = strap_in;
			next_s.out_n = 1'b0;
			next_s.pci = 1'b0;
			next_s.isa = 1'b0;
			next_s.flash_n = 1'b1;
			next_s.open_loop = 1'b1;
		end else begin
			unique case (s.state)
				reset_seq_pkg::ST_HOLD: begin
					// straps frozen from here on; outside party keeps them still
					next_s.state = reset_seq_pkg::ST_SETTLE;
					next_s.open_loop = 1'b0;
					next_s.cnt = '0;
				end
				reset_seq_pkg::ST_SETTLE: begin
					if (s.cnt != CW'(reset_seq_pkg::RELEASE_HOLD_CYC - 1)) begin
						next_s.cnt = s.cnt + 1'b1;
					end else if (link.settled) begin
						// release only after hold time and PLL lock
						next_s.state = reset_seq_pkg::ST_RELEASE;
						next_s.out_n = 1'b1;
						next_s.cnt = '0;
					end
				end
				reset_seq_pkg::ST_RELEASE: begin
					if (s.cnt == CW'(reset_seq_pkg::BUS_START_CYC - 1)) begin
						// bus activity starts a fixed few cycles after release
						next_s.cnt = '0;
						if (s.cfg[ISA]) begin
							next_s.state = reset_seq_pkg::ST_PCI;
							next_s.pci = 1'b1;
						end else begin
							next_s.state = reset_seq_pkg::ST_RUN;
							next_s.flash_n = 1'b0;
						end
					end else begin
						next_s.cnt = s.cnt + 1'b1;
					end
				end
				reset_seq_pkg::ST_PCI: begin
					// south bridge is reached over PCI, so ISA waits
					if (s.cnt == CW'(reset_seq_pkg::PCI_LEAD_CYC - 1)) begin
						next_s.state = reset_seq_pkg::ST_RUN;
						next_s.isa = 1'b1;
						next_s.cnt = '0;
					end else begin
						next_s.cnt = s.cnt + 1'b1;
					end
				end
				reset_seq_pkg::ST_RUN: begin
					next_s.state = reset_seq_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s.state <= reset_seq_pkg::ST_HOLD;
			s.cnt <= '0;
			s.cfg <= STRAP_W'(reset_seq_pkg::STRAP_RESET);
			s.out_n <= 1'b0;
			s.pci <= 1'b0;
			s.isa <= 1'b0;
			s.flash_n <= 1'b1;
			s.open_loop <= 1'b1;
			s.pclk <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign sys_reset_out_n = s.out_n;
	assign strap_cfg = s.cfg;
	assign pci_active = s.pci;
	assign isa_active = s.isa;
	assign flash_cs_n = s.flash_n;
	assign pll_open_loop = s.open_loop;
	assign pci_clk = s.pclk;

	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence release_s;
		$rose(sys_reset_out_n);
	endsequence

	sequence isa_boot_s;
		$rose(pci_active) && strap_cfg[ISA];
	endsequence

	sequence local_boot_s;
		release_s ##0 !strap_cfg[ISA] ##0 sys_reset_in_n [*4];
	endsequence

	strap_follow_a: assert property (!sys_reset_in_n |=> strap_cfg == $past(strap_in))
		else $error("strap configuration did not follow straps in reset");
	strap_frozen_a: assert property (sys_reset_in_n |=> $stable(strap_cfg))
		else $error("strap configuration changed after reset input release");
	out_in_reset_a: assert property (!sys_reset_in_n |=> !sys_reset_out_n)
		else $error("reset output high while reset input low");
	release_settled_a: assert property (release_s |-> $past(link.settled))
		else $error("reset output released before PLL settled");
	no_early_bus_a: assert property (!sys_reset_out_n |-> !pci_active && !isa_active && flash_cs_n)
		else $error("bus activity while reset output low");
	bus_delay_a: assert property (release_s |-> (!pci_active && flash_cs_n) [*4])
		else $error("bus activity too soon after release");
	isa_after_pci_a: assert property (isa_boot_s |-> !isa_active [*8])
		else $error("ISA activity before PCI lead time");
	local_no_pci_a: assert property (!strap_cfg[ISA] |-> !pci_active)
		else $error("PCI activity in local bus mode");
	local_flash_a: assert property (local_boot_s |=> !flash_cs_n)
		else $error("flash select missing in local bus boot");
	open_loop_a: assert property (!sys_reset_in_n |=> pll_open_loop)
		else $error("PLL not open loop during reset");

	// exact boot order in ISA mode; a reset input pulse in mid-lead drops the obligation
	sequence isa_release_s;
		release_s ##0 strap_cfg[ISA] ##0 sys_reset_in_n [*5];
	endsequence

	sequence pci_lead_s;
		isa_boot_s ##0 sys_reset_in_n [*8];
	endsequence

	isa_bus_start_a: assert property (isa_release_s |-> pci_active)
		else $error("PCI activity missing after ISA mode release");
	isa_lead_a: assert property (pci_lead_s |=> isa_active)
		else $error("ISA activity missing after PCI lead time");
	pci_with_isa_a: assert property (isa_active |-> pci_active)
		else $error("ISA activity without PCI activity");
	pci_stands_a: assert property (pci_active && sys_reset_in_n |=> pci_active)
		else $error("PCI activity dropped outside reset");
	isa_stands_a: assert property (isa_active && sys_reset_in_n |=> isa_active)
		else $error("ISA activity dropped outside reset");

	local_no_isa_a: assert property (!strap_cfg[ISA] |-> !isa_active)
		else $error("ISA activity in local bus mode");
	flash_local_a: assert property (!flash_cs_n |-> !strap_cfg[ISA] && !pci_active)
		else $error("flash select outside local bus boot");
	flash_stands_a: assert property (!flash_cs_n && sys_reset_in_n |=> !flash_cs_n)
		else $error("flash select dropped outside reset");
	bus_idle_reset_a: assert property (!sys_reset_in_n |=> !pci_active && !isa_active && flash_cs_n)
		else $error("bus activity left on during reset input");

	// release needs the full hold count of input high behind it
	release_hold_a: assert property (release_s |-> $past(sys_reset_in_n, reset_seq_pkg::RELEASE_HOLD_CYC))
		else $error("reset output released before hold time");
	out_stands_a: assert property (sys_reset_out_n && sys_reset_in_n |=> sys_reset_out_n)
		else $error("reset output fell without reset input");
	pll_kept_a: assert property (sys_reset_out_n |-> link.settled)
		else $error("PLL lost lock while reset output high");
	loop_close_a: assert property ($rose(sys_reset_in_n) |=> !pll_open_loop)
		else $error("PLL loop not closed after reset input release");
	loop_closed_run_a: assert property (sys_reset_out_n |-> !pll_open_loop)
		else $error("PLL open loop while reset output high");
endmodule

// >>> verif/reset_supervisor.sv
// board reset supervisor and strap resistors driving the sequencer
`timescale 1ns/1ps
module reset_supervisor (
	// clock
	input wire logic ref_clk,
	// reset and straps toward the device
	output logic sys_reset_in_n,
	output logic [7:0] strap_in
);
	// power-on: reset low from time zero
	initial begin
		sys_reset_in_n = 1'b0;
		strap_in = 8'h00;
	end
	// clean low level, no glitches; straps may still settle while low
	task automatic hold(input logic [7:0] straps);
		@(negedge ref_clk);
		sys_reset_in_n = 1'b0;
		strap_in = straps;
	endtask
	// straps stay put after release until the next hold
	task automatic release_rst();
		@(negedge ref_clk);
		sys_reset_in_n = 1'b1;
	endtask
endmodule

// >>> verif/cold_warm_reset_sequencer_tb.sv
// self-checking bench for the cold/warm reset sequencer
`timescale 1ns/1ps
module cold_warm_reset_sequencer_tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sys_reset_in_n;
	logic [7:0] strap_in;
	logic [7:0] strap_cfg;
	logic sys_reset_out_n, pci_active, isa_active, flash_cs_n, pll_open_loop, pci_clk;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// three boots of about 330 cycles each, plus slack
	localparam int CYCLE_LIMIT = 3000;
	always #20 ref_clk = ~ref_clk;
	reset_supervisor partner (.ref_clk(ref_clk), .sys_reset_in_n(sys_reset_in_n),
		.strap_in(strap_in));
	cold_warm_reset_sequencer dut (.ref_clk(ref_clk), .resetn(resetn),
		.sys_reset_in_n(sys_reset_in_n), .strap_in(strap_in),
		.sys_reset_out_n(sys_reset_out_n), .strap_cfg(strap_cfg), .pci_active(pci_active),
		.isa_active(isa_active), .flash_cs_n(flash_cs_n), .pll_open_loop(pll_open_loop),
		.pci_clk(pci_clk));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			n_errors++;
			final_report();
		end
	end
	// hold reset low 260 cycles (10 us plus margin), straps changing after the first 100
	task automatic hold_phase(input logic [7:0] a, input logic [7:0] b);
		int toggles;
		logic last;
		partner.hold(a);
		toggles = 0;
		// the copy lags the PLL, so the first edges of a warm reset still show fast toggles
		repeat (4) @(negedge ref_clk);
		last = pci_clk;
		repeat (96) begin
			@(negedge ref_clk);
			if (pci_clk !== last) toggles++;
			last = pci_clk;
		end
		check("strap_cfg early", strap_cfg, a);
		check("open loop", {7'h00, pll_open_loop}, 8'h01);
		check("slow clock", {7'h00, toggles inside {[1:3]}}, 8'h01);
		partner.hold(b);
		repeat (160) @(negedge ref_clk);
		check("strap_cfg late", strap_cfg, b);
		check("out held", {7'h00, sys_reset_out_n}, 8'h00);
	endtask
	// release, wait for the reset output, then walk the bus start order
	task automatic release_phase(input logic [7:0] b, input logic isa);
		int waited;
		logic last;
		partner.release_rst();
		repeat (2) @(negedge ref_clk);
		check("loop closed", {7'h00, pll_open_loop}, 8'h00);
		waited = 2;
		while (sys_reset_out_n !== 1'b1 && waited < 200) begin
			check("idle pre", {5'h00, pci_active, isa_active, flash_cs_n}, 8'h01);
			@(negedge ref_clk);
			waited++;
		end
		check("out delayed", {7'h00, waited > 25 && waited < 200}, 8'h01);
		last = pci_clk;
		for (int i = 1; i <= 12; i++) begin
			@(negedge ref_clk);
			check("strap frozen", strap_cfg, b);
			check("fast clock", {7'h00, pci_clk !== last}, 8'h01);
			last = pci_clk;
			if (isa) begin
				check("pci isa", {6'h00, pci_active, isa_active}, {6'h00, i >= 4, i >= 12});
			end else begin
				check("local", {5'h00, pci_active, isa_active, flash_cs_n}, {7'h00, i < 4});
			end
		end
	endtask
	task automatic cold_boot_local();
		hold_phase(8'h5b, 8'ha6);
		release_phase(8'ha6, 1'b0);
	endtask
	// warm resets straight after a finished boot, both modes
	task automatic warm_boot_isa();
		hold_phase(8'h3c, 8'h71);
		release_phase(8'h71, 1'b1);
	endtask
	task automatic warm_boot_local();
		hold_phase(8'h71, 8'h42);
		release_phase(8'h42, 1'b0);
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (3) @(negedge ref_clk);
		cold_boot_local();
		warm_boot_isa();
		warm_boot_local();
		final_report();
	end
endmodule
